/* inc/pmos_consts.vh */
`ifndef PMOS_CONSTS_VH
`define PMOS_CONSTS_VH

// register byte addresses
`define PMOS_PCTL_ADDR   8'h00
`define PMOS_STAT_ADDR   8'h04

// power_control_reg fields
`define PMOS_IDLE_REQ    0
`define PMOS_PD_REQ      1
`define PMOS_SLOW        4
`define PMOS_IDLE_CONF   5
`define PMOS_PD_CONF     6
`define PMOS_PCTL_RST    8'h00

// status register fields
`define PMOS_ST_STATE_LO 0
`define PMOS_ST_SLOW     3
`define PMOS_ST_OSC_OK   4
`define PMOS_ST_WAKE     5
`define PMOS_ST_RESET    6

// slow-down divider
`define PMOS_SLOW_DIV    32
`define PMOS_DIV_W       5
`define PMOS_DIV_LAST    5'h1F

// timing
`define PMOS_CLK_KHZ     40000
`define PMOS_STAB_US     1000
`define PMOS_STAB_CYC    ((`PMOS_STAB_US * `PMOS_CLK_KHZ) / 1000)
`define PMOS_STAB_W      16

`endif

/* design/pmos_top.v */
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pmos_consts.vh"

module pmos_top #(
  parameter [`PMOS_STAB_W-1:0] STAB_CYC = `PMOS_STAB_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // pins and analog status
  input  wire        hw_powerdown_n_pin,
  input  wire        wake_pin,
  input  wire        main_osc_fast,
  // from interrupt controller
  input  wire        irq_pending,
  // clock and reset control
  output reg         core_reset_r,
  output reg         cpu_clk_en_r,
  output reg         periph_clk_en_r,
  output reg         rc_osc_en_r,
  output reg         main_osc_en_r,
  output reg         clk_sel_rc_r,
  output reg         port_float_r,
  output reg         wake_irq_r
);

  localparam [2:0] ST_OSC_WAIT = 3'h0;
  localparam [2:0] ST_STAB     = 3'h1;
  localparam [2:0] ST_RUN      = 3'h2;
  localparam [2:0] ST_IDLE     = 3'h3;
  localparam [2:0] ST_SPD      = 3'h4;
  localparam [2:0] ST_PINPD    = 3'h5;

  // states in which the main oscillator drives the core
  function clocked_state;
    input [2:0] st;
    begin
      clocked_state = (st == ST_RUN) || (st == ST_IDLE);
    end
  endfunction

  // states waiting on the oscillator
  function recovering_state;
    input [2:0] st;
    begin
      recovering_state = (st == ST_OSC_WAIT) || (st == ST_STAB);
    end
  endfunction

  // synchronisers
  reg        pdpin_s1_r;
  reg        pdpin_s2_r;
  reg        wake_s1_r;
  reg        wake_s2_r;
  reg        ofast_s1_r;
  reg        ofast_s2_r;

  // core state
  reg [2:0]             state_r;
  reg [2:0]             state_nxt;
  reg [`PMOS_STAB_W-1:0] stab_cnt_r;
  reg [`PMOS_STAB_W-1:0] stab_cnt_nxt;
  reg                   wake_path_r;
  reg                   wake_path_nxt;
  reg [`PMOS_DIV_W-1:0] div_cnt_r;
  reg [7:0]             pctl_r;
  reg [7:0]             pctl_nxt;
  reg                   prev_idle_r;
  reg                   prev_pd_r;

  // ahb data phase
  reg        dph_wr_r;
  reg [7:0]  dph_addr_r;

  wire       addr_ok   = hsel && htrans[1] && hready;
  wire       wr_pctl   = dph_wr_r && (dph_addr_r == `PMOS_PCTL_ADDR);
  wire       idle_go   = wr_pctl && hwdata[`PMOS_IDLE_CONF] && prev_idle_r;
  wire       pd_go     = wr_pctl && hwdata[`PMOS_PD_CONF] && prev_pd_r;
  wire       slow      = pctl_r[`PMOS_SLOW];
  wire       div_tick  = !slow || (div_cnt_r == `PMOS_DIV_LAST);
  wire       hold_rst_nxt;
  wire [7:0] stat_val;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pdpin_s1_r <= 1'b1;
      pdpin_s2_r <= 1'b1;
      wake_s1_r  <= 1'b1;
      wake_s2_r  <= 1'b1;
      ofast_s1_r <= 1'b0;
      ofast_s2_r <= 1'b0;
    end else begin
      pdpin_s1_r <= hw_powerdown_n_pin;
      pdpin_s2_r <= pdpin_s1_r;
      wake_s1_r  <= wake_pin;
      wake_s2_r  <= wake_s1_r;
      ofast_s1_r <= main_osc_fast;
      ofast_s2_r <= ofast_s1_r;
    end
  end

  // mode sequencer
  always @* begin
    state_nxt     = state_r;
    stab_cnt_nxt  = stab_cnt_r;
    wake_path_nxt = wake_path_r;
    if (!pdpin_s2_r) begin
      state_nxt     = ST_PINPD;
      wake_path_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_OSC_WAIT: begin
          stab_cnt_nxt = {`PMOS_STAB_W{1'b0}};
          if (ofast_s2_r) begin
            state_nxt = ST_STAB;
          end
        end
        ST_STAB: begin
          if (!ofast_s2_r) begin
            state_nxt = ST_OSC_WAIT;
          end else if (stab_cnt_r == STAB_CYC - 1'b1) begin
            state_nxt = ST_RUN;
          end else begin
            stab_cnt_nxt = stab_cnt_r + 1'b1;
          end
        end
        ST_RUN: begin
          if (!ofast_s2_r) begin
            state_nxt     = ST_OSC_WAIT;
            wake_path_nxt = 1'b0;
          end else if (pd_go) begin
            state_nxt = ST_SPD;
          end else if (idle_go) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!ofast_s2_r) begin
            state_nxt     = ST_OSC_WAIT;
            wake_path_nxt = 1'b0;
          end else if (irq_pending) begin
            state_nxt = ST_RUN;
          end
        end
        ST_SPD: begin
          if (!wake_s2_r) begin
            state_nxt     = ST_OSC_WAIT;
            wake_path_nxt = 1'b1;
          end
        end
        ST_PINPD: begin
          state_nxt     = ST_OSC_WAIT;
          wake_path_nxt = 1'b0;
        end
        default: begin
          state_nxt     = ST_OSC_WAIT;
          wake_path_nxt = 1'b0;
        end
      endcase
    end
    if (state_r == ST_STAB && state_nxt == ST_RUN) begin
      wake_path_nxt = 1'b0;
    end
  end

  // core held in reset in pin power-down and while waiting on the oscillator, except on the wake-pin path
  assign hold_rst_nxt = (state_nxt == ST_PINPD) ||
                        (recovering_state(state_nxt) && !wake_path_nxt);

  // power control register
  always @* begin
    pctl_nxt = pctl_r;
    if (hold_rst_nxt) begin
      pctl_nxt = `PMOS_PCTL_RST;
    end else if (wr_pctl) begin
      pctl_nxt = 8'h00;
      pctl_nxt[`PMOS_IDLE_REQ] = hwdata[`PMOS_IDLE_REQ] && !idle_go;
      pctl_nxt[`PMOS_PD_REQ]   = hwdata[`PMOS_PD_REQ] && !pd_go;
      pctl_nxt[`PMOS_SLOW]     = hwdata[`PMOS_SLOW];
    end
  end

  assign stat_val = {1'b0, core_reset_r, wake_path_r, ofast_s2_r, slow, state_r};

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= ST_OSC_WAIT;
      stab_cnt_r  <= {`PMOS_STAB_W{1'b0}};
      wake_path_r <= 1'b0;
      div_cnt_r   <= {`PMOS_DIV_W{1'b0}};
      pctl_r      <= `PMOS_PCTL_RST;
      prev_idle_r <= 1'b0;
      prev_pd_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      stab_cnt_r  <= stab_cnt_nxt;
      wake_path_r <= wake_path_nxt;
      div_cnt_r   <= div_cnt_r + 1'b1;
      pctl_r      <= pctl_nxt;
      if (hold_rst_nxt) begin
        prev_idle_r <= 1'b0;
        prev_pd_r   <= 1'b0;
      end else if (wr_pctl) begin
        // a confirm only counts if the write just before set the request
        prev_idle_r <= hwdata[`PMOS_IDLE_REQ] && !hwdata[`PMOS_IDLE_CONF];
        prev_pd_r   <= hwdata[`PMOS_PD_REQ] && !hwdata[`PMOS_PD_CONF];
      end
    end
  end

  // clock and reset controls
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_reset_r    <= 1'b1;
      cpu_clk_en_r    <= 1'b0;
      periph_clk_en_r <= 1'b0;
      rc_osc_en_r     <= 1'b1;
      main_osc_en_r   <= 1'b1;
      clk_sel_rc_r    <= 1'b1;
      port_float_r    <= 1'b0;
      wake_irq_r      <= 1'b0;
    end else begin
      core_reset_r    <= hold_rst_nxt;
      cpu_clk_en_r    <= div_tick && (state_nxt == ST_RUN);
      periph_clk_en_r <= div_tick && clocked_state(state_nxt);
      rc_osc_en_r     <= !(state_nxt == ST_SPD || state_nxt == ST_PINPD);
      main_osc_en_r   <= !(state_nxt == ST_SPD || state_nxt == ST_PINPD);
      clk_sel_rc_r    <= !clocked_state(state_nxt);
      port_float_r    <= (state_nxt == ST_PINPD);
      // wake handler only once nominal clock is back
      wake_irq_r      <= wake_path_r && (state_r == ST_STAB) && (state_nxt == ST_RUN);
    end
  end

  // ahb-lite slave, zero wait states
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        dph_wr_r   <= addr_ok && hwrite;
        dph_addr_r <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        // read the post-write value so a write then read sees fresh data
        case (haddr[7:0])
          `PMOS_PCTL_ADDR: hrdata <= {24'h00_0000, pctl_nxt};
          `PMOS_STAT_ADDR: hrdata <= {24'h00_0000, stat_val};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // pmos_top

`default_nettype wire

/* testbench/pmos_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module pmos_chk #(
  parameter int STAB_CYC = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // pins and status
  input wire logic hw_powerdown_n_pin,
  input wire logic main_osc_fast,
  input wire logic irq_pending,
  // clock and reset control
  input wire logic core_reset_r,
  input wire logic cpu_clk_en_r,
  input wire logic periph_clk_en_r,
  input wire logic rc_osc_en_r,
  input wire logic main_osc_en_r,
  input wire logic clk_sel_rc_r,
  input wire logic port_float_r,
  input wire logic wake_irq_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence osc_lost_s; !main_osc_fast [*4]; endsequence
  sequence idle_irq_s; periph_clk_en_r && !cpu_clk_en_r && irq_pending; endsequence
  sequence nominal_s; !core_reset_r && !clk_sel_rc_r ##1 !wake_irq_r; endsequence
  rst_on_rc_a: assert property (core_reset_r |-> clk_sel_rc_r)
    else $error("reset not on rc clock");
  osc_loss_a: assert property (osc_lost_s |-> clk_sel_rc_r)
    else $error("slow oscillator not replaced by rc");
  stab_wait_a: assert property ($fell(core_reset_r) |-> $past(main_osc_fast, STAB_CYC))
    else $error("reset left before settling time");
  pd_stop_a: assert property (!rc_osc_en_r |-> !main_osc_en_r && !cpu_clk_en_r && !periph_clk_en_r)
    else $error("activity while oscillators stopped");
  hw_pd_a: assert property (!hw_powerdown_n_pin [*4] |->
    core_reset_r && port_float_r && !main_osc_en_r)
    else $error("pin power-down not applied");
  idle_gate_a: assert property (cpu_clk_en_r |-> periph_clk_en_r)
    else $error("cpu clocked without peripherals");
  idle_exit_a: assert property (idle_irq_s |-> ##[1:34] cpu_clk_en_r)
    else $error("idle not left on interrupt");
  wake_nom_a: assert property ($rose(wake_irq_r) |-> nominal_s)
    else $error("wake handler not at nominal clock");
endmodule // pmos_chk
bind pmos_top pmos_chk #(.STAB_CYC(STAB_CYC)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .hw_powerdown_n_pin(hw_powerdown_n_pin), .main_osc_fast(main_osc_fast),
  .irq_pending(irq_pending), .core_reset_r(core_reset_r), .cpu_clk_en_r(cpu_clk_en_r),
  .periph_clk_en_r(periph_clk_en_r), .rc_osc_en_r(rc_osc_en_r), .main_osc_en_r(main_osc_en_r),
  .clk_sel_rc_r(clk_sel_rc_r), .port_float_r(port_float_r), .wake_irq_r(wake_irq_r));
`default_nettype wire

/* testbench/pmos_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmos_osc_model #(
  parameter int START_CYC = 4
) (
  // clock
  input  wire logic sys_clk,
  // oscillator control and comparator
  input  wire logic osc_en,
  input  wire logic rc_en,
  input  wire logic fail,
  output wire logic osc_fast
);
  int cnt = 0;
  // comparator stays slow until the crystal has swung a while after enable
  always @(posedge sys_clk)
    cnt <= (!osc_en || !rc_en || fail) ? 0 : (cnt < START_CYC) ? cnt + 1 : cnt;
  assign osc_fast = (cnt >= START_CYC) && !fail;
endmodule // pmos_osc_model
`default_nettype wire

/* testbench/pmos_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pmos_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
`define WAITF(c) begin int n; n = 0; \
  while (!(c) && n < 300) begin @(posedge sys_clk); #1; n++; end \
  if (!(c)) error_cnt++; end
module pmos_tb_top;
  logic             sys_clk, arst_n, hsel, hwrite, hw_pd_n, wake, irq, osc_fail;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, rd_q;
  wire logic        hreadyout, hresp, core_rst, cpu_en, per_en, rc_en, osc_en;
  wire logic        rc_sel, flt, wk, fast;
  wire logic [31:0] hrdata;
  int               error_cnt = 0, total_checks = 0, cyc = 0, cc, pc;

  pmos_top #(.STAB_CYC(16'h0008)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .hw_powerdown_n_pin(hw_pd_n), .wake_pin(wake), .main_osc_fast(fast), .irq_pending(irq),
    .core_reset_r(core_rst), .cpu_clk_en_r(cpu_en), .periph_clk_en_r(per_en),
    .rc_osc_en_r(rc_en), .main_osc_en_r(osc_en), .clk_sel_rc_r(rc_sel), .port_float_r(flt),
    .wake_irq_r(wk));
  pmos_osc_model u_osc (.sys_clk(sys_clk), .osc_en(osc_en), .rc_en(rc_en), .fail(osc_fail),
    .osc_fast(fast));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
    #1;
  endtask
  task automatic chk_state(input logic [2:0] e);
    xfer(1'b0, `PMOS_STAT_ADDR, 8'h00);
    `CHK("state", e, rd_q[2:0])
  endtask
  // counts enables over a window of two full divider turns
  task automatic count64;
    cc = 0;
    pc = 0;
    repeat (64) begin
      @(posedge sys_clk);
      #1;
      cc += cpu_en;
      pc += per_en;
    end
  endtask
  task automatic irq_exit;
    @(posedge sys_clk);
    irq <= 1'b1;
    `WAITF(cpu_en === 1'b1)
    irq <= 1'b0;
    chk_state(3'h2);
  endtask
  task automatic t_boot;
    int t0;
    @(posedge sys_clk);
    #1;
    `CHK("core_rst", 1'b1, core_rst)
    `CHK("rc_sel", 1'b1, rc_sel)
    `WAITF(fast === 1'b1)
    t0 = cyc;
    `WAITF(core_rst === 1'b0)
    `CHK("stab", 1'b1, (cyc - t0) >= 8)
    `CHK("rc_sel", 1'b0, rc_sel)
    chk_state(3'h2);
    $display("boot done");
  endtask
  task automatic t_idle;
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h20);
    chk_state(3'h2);
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h01);
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h21);
    chk_state(3'h3);
    `CHK("cpu_en", 1'b0, cpu_en)
    `CHK("per_en", 1'b1, per_en)
    irq_exit();
    $display("idle done");
  endtask
  task automatic t_slow;
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h10);
    count64();
    `CHK("cpu_div", 2, cc)
    `CHK("per_div", 2, pc)
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h11);
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h31);
    chk_state(3'h3);
    count64();
    `CHK("idle_cpu", 0, cc)
    `CHK("idle_per", 2, pc)
    irq_exit();
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h00);
    xfer(1'b0, `PMOS_PCTL_ADDR, 8'h00);
    count64();
    `CHK("cpu_full", 64, cc)
    $display("slow done");
  endtask
  task automatic t_spd;
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h12);
    xfer(1'b1, `PMOS_PCTL_ADDR, 8'h52);
    `WAITF(rc_en === 1'b0)
    `CHK("osc_en", 1'b0, osc_en)
    chk_state(3'h4);
    @(posedge sys_clk);
    wake <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wake <= 1'b1;
    `WAITF(wk === 1'b1 || core_rst === 1'b1)
    `CHK("wake_irq", 1'b1, wk)
    `CHK("rc_sel", 1'b0, rc_sel)
    `CHK("core_rst", 1'b0, core_rst)
    `CHK("rc_en", 1'b1, rc_en)
    xfer(1'b0, `PMOS_PCTL_ADDR, 8'h00);
    `CHK("pwr_ctl", 32'h00000010, rd_q)
    $display("spd done");
  endtask
  task automatic t_hw_powerdown_n_pin;
    @(posedge sys_clk);
    hw_pd_n <= 1'b0;
    `WAITF(flt === 1'b1)
    `CHK("core_rst", 1'b1, core_rst)
    `CHK("osc_en", 1'b0, osc_en)
    hw_pd_n <= 1'b1;
    `WAITF(core_rst === 1'b0)
    `CHK("released", 1'b0, core_rst)
    `CHK("flt", 1'b0, flt)
    xfer(1'b0, `PMOS_PCTL_ADDR, 8'h00);
    `CHK("pwr_ctl", 32'h00000000, rd_q)
    $display("hw_powerdown_n_pin done");
  endtask
  task automatic t_osc;
    @(posedge sys_clk);
    osc_fail <= 1'b1;
    `WAITF(core_rst === 1'b1)
    `CHK("rc_sel", 1'b1, rc_sel)
    osc_fail <= 1'b0;
    `WAITF(core_rst === 1'b0)
    chk_state(3'h2);
    xfer(1'b0, 8'h08, 8'h00);
    `CHK("unmapped", 32'h00000000, rd_q)
    `CHK("hresp", 1'b0, hresp)
    $display("osc done");
  endtask

  initial begin
    {arst_n, hsel, hwrite, irq, osc_fail} = 5'h00;
    {hw_pd_n, wake} = 2'h3;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_boot();
    t_idle();
    t_slow();
    t_spd();
    t_hw_powerdown_n_pin();
    t_osc();
    report_and_stop();
  end
endmodule // pmos_tb_top
`default_nettype wire
